// file: pkg/rmiiph_pkg.sv
/*
  Constants for the RMII transceiver interface block: register indexes,
  field positions, reset values and clock ratios.
  Assumes a 250 MHz system clock and 32-bit AHB-Lite register access.
*/
// -----------------------------------------------------------------------
// rmiiph_pkg
// -----------------------------------------------------------------------
package rmiiph_pkg;
  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_STAT = 6'h10;
  localparam logic [5:0] IDX_MODE = 6'h1F;
  // control register fields
  localparam int CTRL_AN_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_DUPLEX_BIT = 8;
  // clock mode register field
  localparam int MODE_CLK_BIT = 7;
  // advertisement ability field: 100FD,100HD,10FD,10HD
  localparam int ADV_LSB = 5;
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [3:0] ADV_10ONLY = 4'h3;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h3100;
  localparam logic [15:0] ADV_RST = 16'h01E1;
  localparam logic [15:0] MODE_RST = 16'h0000;
  // clocking
  localparam int SYS_CLK_MHZ = 250;
  localparam int REF_CLK_MHZ = 50;
  localparam int REF_DIV = SYS_CLK_MHZ / REF_CLK_MHZ;
  localparam logic [2:0] REF_DIV_LAST = 3'(REF_DIV - 1);
  localparam logic [2:0] REF_HIGH_CNT = 3'(REF_DIV / 2);
  localparam int DIBIT_REPEAT_10M = 10;
  localparam logic [3:0] DIBIT_LAST_10M = 4'(DIBIT_REPEAT_10M - 1);
  // receive path states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_WAIT = 3'b010,
    RX_DATA = 3'b100
  } rmiiph_rx_t;
endpackage : rmiiph_pkg

// file: hw/rmiiph_top.sv
/*
  RMII interface logic of a 10/100 transceiver: reference clock
  generation, transmit dibit capture, receive carrier/data/error
  delivery, speed and duplex resolution, AHB-Lite register slave.
  Assumes the line side delivers decoded dibits on ref_clk and that
  MAC pins and straps are asynchronous to ref_clk.
*/
// Contract
// - one 50 MHz reference times all RMII signals
// - 25 MHz mode: synthesize and drive reference
// - 50 MHz mode: reference from crystal input
// - mode register bit 7 picks non-default mode
// - accept transmit dibit each enabled clock
// - ignore transmit data while enable low
// - raise carrier sense at once on carrier
// - carrier sense spans first to last dibit
// - receive data 00 until decoding starts
// - deliver one dibit per valid clock
// - receive data 00 while carrier sense low
// - receive error flags coding errors in frame
// - negotiation picks highest common mode
// - parallel detection without partner negotiation
// - control bits 12, 13, 8 steer mode
// - receive timing keeps running when idle
// - independent paths, both speeds, both duplexes
// - strap latched at reset release
`timescale 1ns/1ps
`default_nettype none
module rmiiph_top #(
  parameter bit DEFAULT_MODE50 = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic crystal_input,
  output logic refClkOut,
  output logic refClkOutEn,
  input wire logic txEn,
  input wire logic [1:0] txd,
  output logic crsDv,
  output logic [1:0] rxd,
  output logic rxEr,
  input wire logic autoneg_speed_strap,
  output logic lineTxValid,
  output logic [1:0] lineTxDibit,
  input wire logic lineCarrier,
  input wire logic lineRxValid,
  input wire logic [1:0] lineRxDibit,
  input wire logic lineSymErr,
  input wire logic partnerNegotiates,
  input wire logic [3:0] partnerAbility,
  input wire logic parallelSpeed100,
  output logic linkSpeed100,
  output logic linkFullDuplex
);
  import rmiiph_pkg::*;

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [5:0] pinIn;
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic xiS, txEnS, carS, strapS;
  logic [1:0] txdS;
  assign pinIn = {crystal_input, txEn, txd, lineCarrier, autoneg_speed_strap};
  // data-only flops; no reset so the strap is valid at release
  always_ff @(posedge ref_clk) begin
    syncA_q <= pinIn;
    syncB_q <= syncA_q;
  end
  assign {xiS, txEnS, txdS, carS, strapS} = syncB_q;

  // -------------------------------------------------------------------
  // registers and strap
  // -------------------------------------------------------------------
  logic [15:0] ctrl_q, adv_q, mode_q;
  logic strapPend_q;
  logic mode50;
  logic wrPend_q;
  logic [5:0] wrIdx_q;
  logic addrOk;
  logic addrPhase;
  assign mode50 = DEFAULT_MODE50 ^ mode_q[MODE_CLK_BIT];

  // pending flag marks the first cycle after release for the strap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strapPend_q <= 1'b1;
    end else begin
      strapPend_q <= 1'b0;
    end
  end

  // strap load wins once, later writes from software steer the mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      adv_q <= ADV_RST;
      mode_q <= MODE_RST;
    end else if (strapPend_q) begin
      ctrl_q[CTRL_AN_BIT] <= strapS;
      ctrl_q[CTRL_SPEED_BIT] <= strapS;
      adv_q[ADV_LSB +: 4] <= strapS ? ADV_ALL : ADV_10ONLY;
    end else if (wrPend_q) begin
      unique case (wrIdx_q)
        IDX_CTRL: ctrl_q <= hwdata[15:0];
        IDX_ADV: adv_q <= hwdata[15:0];
        IDX_MODE: mode_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // -------------------------------------------------------------------
  logic [31:0] hrdata_q;
  logic [15:0] stat;
  logic rxActive;
  assign addrOk = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign stat = {11'h000, rxActive, mode50, ctrl_q[CTRL_AN_BIT], linkSpeed100, linkFullDuplex};

  // a write lands at the end of its data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 6'h00;
    end else begin
      wrPend_q <= addrPhase && hwrite && addrOk;
      wrIdx_q <= haddr[7:2];
    end
  end

  // read data captured at the address phase; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_q <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= 32'h00000000;
      if (addrOk) begin
        unique case (haddr[7:2])
          IDX_CTRL: hrdata_q <= {16'h0000, ctrl_q};
          IDX_ADV: hrdata_q <= {16'h0000, adv_q};
          IDX_STAT: hrdata_q <= {16'h0000, stat};
          IDX_MODE: hrdata_q <= {16'h0000, mode_q};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // reference clock and tick
  // -------------------------------------------------------------------
  logic [2:0] divCnt_q;
  logic divTick;
  logic xiPrev_q;
  logic tick;
  logic refClkOut_q, refClkOutEn_q;
  assign divTick = (divCnt_q == REF_DIV_LAST);
  // one tick per reference period, from divider or crystal input edge
  assign tick = mode50 ? (xiS && !xiPrev_q) : divTick;
  assign refClkOut = refClkOut_q;
  assign refClkOutEn = refClkOutEn_q;

  // divider runs free; 2/5 duty is the closest split of five cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divCnt_q <= 3'h0;
      refClkOut_q <= 1'b0;
      refClkOutEn_q <= 1'b0;
      xiPrev_q <= 1'b0;
    end else begin
      divCnt_q <= divTick ? 3'h0 : divCnt_q + 3'h1;
      refClkOut_q <= !mode50 && (divTick || divCnt_q < REF_HIGH_CNT - 3'h1);
      refClkOutEn_q <= !mode50;
      xiPrev_q <= xiS;
    end
  end

  // -------------------------------------------------------------------
  // transmit path
  // -------------------------------------------------------------------
  logic [3:0] txCnt_q;
  logic txStrobe;
  logic lineTxValid_q;
  logic [1:0] lineTxDibit_q;
  assign txStrobe = tick && (linkSpeed100 || txCnt_q == 4'h0);
  assign lineTxValid = lineTxValid_q;
  assign lineTxDibit = lineTxDibit_q;

  // frame bounds come from the enable alone; the MAC keeps it framed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txCnt_q <= 4'h0;
      lineTxValid_q <= 1'b0;
      lineTxDibit_q <= 2'b00;
    end else begin
      if (tick) begin
        txCnt_q <= (!txEnS || txCnt_q == DIBIT_LAST_10M) ? 4'h0 : txCnt_q + 4'h1;
      end
      lineTxValid_q <= txStrobe && txEnS;
      if (txStrobe) begin
        lineTxDibit_q <= txEnS ? txdS : 2'b00;
      end
    end
  end

  // -------------------------------------------------------------------
  // receive path
  // -------------------------------------------------------------------
  rmiiph_rx_t rxState_q;
  logic [3:0] rxCnt_q;
  logic rxStrobe;
  logic pend_q, errPend_q;
  logic [1:0] pendD_q;
  logic crsDv_q, rxEr_q;
  logic [1:0] rxd_q;
  // tick runs through idle gaps, so receive timing never stops
  assign rxStrobe = tick && (linkSpeed100 || rxCnt_q == 4'h0);
  assign rxActive = (rxState_q != RX_IDLE);
  assign crsDv = crsDv_q;
  assign rxd = rxd_q;
  assign rxEr = rxEr_q;

  // one-dibit holding stage; a new dibit wins over the consume
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      pendD_q <= 2'b00;
      errPend_q <= 1'b0;
    end else begin
      if (lineRxValid) begin
        pend_q <= 1'b1;
        pendD_q <= lineRxDibit;
      end else if (rxStrobe) begin
        pend_q <= 1'b0;
      end
      if (lineSymErr && rxActive) begin
        errPend_q <= 1'b1;
      end else if (rxStrobe || !rxActive) begin
        errPend_q <= 1'b0;
      end
    end
  end

  // repeat counter restarts at carrier so the first dibit is aligned
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxCnt_q <= 4'h0;
    end else if (rxState_q == RX_IDLE) begin
      rxCnt_q <= 4'h0;
    end else if (tick) begin
      rxCnt_q <= (rxCnt_q == DIBIT_LAST_10M) ? 4'h0 : rxCnt_q + 4'h1;
    end
  end

  // carrier rise is taken at once, not on a tick; drops only on a tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxState_q <= RX_IDLE;
      crsDv_q <= 1'b0;
      rxd_q <= 2'b00;
      rxEr_q <= 1'b0;
    end else begin
      unique case (rxState_q)
        RX_IDLE: begin
          rxd_q <= 2'b00;
          rxEr_q <= 1'b0;
          if (carS) begin
            rxState_q <= RX_WAIT;
            crsDv_q <= 1'b1;
          end
        end
        RX_WAIT, RX_DATA: begin
          if (rxStrobe) begin
            if (pend_q) begin
              rxState_q <= RX_DATA;
              rxd_q <= pendD_q;
              rxEr_q <= errPend_q || lineSymErr;
            end else if (!carS) begin
              rxState_q <= RX_IDLE;
              crsDv_q <= 1'b0;
              rxd_q <= 2'b00;
              rxEr_q <= 1'b0;
            end else begin
              rxd_q <= 2'b00;
              rxEr_q <= errPend_q;
            end
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // speed and duplex resolution
  // -------------------------------------------------------------------
  logic [3:0] common;
  logic speedD, fullD;
  logic linkSpeed100_q, linkFull_q;
  assign common = adv_q[ADV_LSB +: 4] & partnerAbility;
  assign linkSpeed100 = linkSpeed100_q;
  assign linkFullDuplex = linkFull_q;

  // priority encoder over the common abilities, highest first
  always_comb begin
    speedD = ctrl_q[CTRL_SPEED_BIT];
    fullD = ctrl_q[CTRL_DUPLEX_BIT];
    if (ctrl_q[CTRL_AN_BIT]) begin
      if (!partnerNegotiates) begin
        speedD = parallelSpeed100;
        fullD = 1'b0;
      end else if (common[3]) begin
        speedD = 1'b1;
        fullD = 1'b1;
      end else if (common[2]) begin
        speedD = 1'b1;
        fullD = 1'b0;
      end else begin
        speedD = 1'b0;
        fullD = common[1];
      end
    end
  end

  // result is registered so both paths see a stable rate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      linkSpeed100_q <= 1'b1;
      linkFull_q <= 1'b1;
    end else begin
      linkSpeed100_q <= speedD;
      linkFull_q <= fullD;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  AST_TX_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    txStrobe && !txEnS |=> !lineTxValid_q && lineTxDibit_q == 2'b00)
    else $error("transmit accepted while enable low");
  AST_TX_ACCEPT: assert property (@(posedge ref_clk) disable iff (rst)
    txStrobe && txEnS |=> lineTxValid_q && lineTxDibit_q == $past(txdS))
    else $error("enabled transmit dibit not taken");
  AST_RX_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !crsDv_q |-> rxd_q == 2'b00 && !rxEr_q)
    else $error("receive data not idle without carrier sense");
  AST_CRS_RISE: assert property (@(posedge ref_clk) disable iff (rst)
    rxState_q == RX_IDLE && carS |=> crsDv_q && rxd_q == 2'b00)
    else $error("carrier sense late on carrier");
  AST_CRS_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    crsDv_q && !rxStrobe |=> crsDv_q)
    else $error("carrier sense dropped off a clock edge");
  AST_10M_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !linkSpeed100 && crsDv_q && !rxStrobe |=> $stable(rxd_q))
    else $error("10 Mbps receive dibit not held");
  AST_REF_PERIOD: assert property (@(posedge ref_clk) disable iff (rst)
    !mode50 && divTick |-> ##5 divTick)
    else $error("reference divider period wrong");
  AST_REF_NC: assert property (@(posedge ref_clk) disable iff (rst)
    mode50 |=> !refClkOutEn_q && !refClkOut_q)
    else $error("reference output driven in 50 MHz mode");
  AST_FORCED: assert property (@(posedge ref_clk) disable iff (rst)
    !ctrl_q[CTRL_AN_BIT] |=> linkSpeed100_q == $past(ctrl_q[CTRL_SPEED_BIT])
      && linkFull_q == $past(ctrl_q[CTRL_DUPLEX_BIT]))
    else $error("forced speed or duplex not applied");
  AST_AN_BEST: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_q[CTRL_AN_BIT] && partnerNegotiates && common[3] |=> linkSpeed100_q && linkFull_q)
    else $error("negotiation missed the best common mode");
endmodule : rmiiph_top
`default_nettype wire

// file: bench/rmiiph_mac_model.sv
/*
  MAC model for the RMII transmit pins: sends one frame of up to eight
  dibits per request, each dibit held for rep reference ticks.
  Assumes ticks are rising edges of refClkOut, or of crystal_input in
  50 MHz mode, both seen through ref_clk sampling.
*/
`timescale 1ns/1ps
`default_nettype none
module rmiiph_mac_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mode50,
  input wire logic refClkOut,
  input wire logic crystal_input,
  input wire logic sendReq,
  input wire logic idleJunk,
  input wire logic [15:0] pattern,
  input wire logic [3:0] nDibits,
  input wire logic [3:0] rep,
  output logic sendDone,
  output logic txEn,
  output logic [1:0] txd
);
  logic refPrev;
  logic tick;
  logic [3:0] idx;
  logic [3:0] hold;
  // -----------------------------------------------------------------
  // tick finder and frame sender
  // -----------------------------------------------------------------
  // the reference is edge-detected with no synchroniser, so a tick shows in the cycle it rises
  assign tick = (mode50 ? crystal_input : refClkOut) & ~refPrev;
  always_ff @(posedge ref_clk) refPrev <= mode50 ? crystal_input : refClkOut;
  // pins move just after a tick, so they settle long before the next
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txEn <= 1'b0;
      txd <= 2'h0;
      idx <= 4'h0;
      hold <= 4'h0;
      sendDone <= 1'b0;
    end else if (tick && sendReq && hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else if (tick && sendReq && idx < nDibits) begin
      txEn <= 1'b1;
      txd <= pattern[15 - 2 * idx -: 2];
      idx <= idx + 4'h1;
      hold <= rep - 4'h1;
    end else if (tick) begin
      txEn <= 1'b0;
      txd <= idleJunk ? 2'h3 : 2'h0; // junk on command only
      sendDone <= sendReq;
      if (!sendReq) idx <= 4'h0;
    end
  end
endmodule : rmiiph_mac_model
`default_nettype wire

// file: bench/rmiiph_top_bench.sv
/*
  Self-checking bench for rmiiph_top: AHB-Lite tasks, MAC model on the
  transmit pins, line-side receive stimulus, link resolution checks.
  Assumes zero-wait answers and the 25 MHz default variant.
*/
`timescale 1ns/1ps
`default_nettype none
module rmiiph_top_bench;
  import rmiiph_pkg::*;
  localparam logic [5:0] NEG [6] = '{6'h23, 6'h12, 6'h09, 6'h04, 6'h1A, 6'h3F};
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, crystal_input = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, lineRxDibit = 2'h0, txd, rxd, lineTxDibit;
  logic hreadyout, hresp, refClkOut, refClkOutEn, txEn, crsDv, rxEr, lineTxValid;
  logic autoneg_speed_strap = 1'b1, lineCarrier = 1'b0, lineRxValid = 1'b0;
  logic lineSymErr = 1'b0, partnerNegotiates = 1'b1, parallelSpeed100 = 1'b0;
  logic [3:0] partnerAbility = 4'hF, nDibits = 4'h0, rep = 4'h1;
  logic linkSpeed100, linkFullDuplex, sendReq = 1'b0, sendDone, mode50 = 1'b0;
  logic [15:0] pattern = 16'h0, txCap = 16'h0;
  int n_errors = 0, compares = 0, cycles = 0, txCnt = 0;
  rmiiph_top u_rmiiph_top (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .crystal_input(crystal_input),
    .refClkOut(refClkOut), .refClkOutEn(refClkOutEn), .txEn(txEn), .txd(txd),
    .crsDv(crsDv), .rxd(rxd), .rxEr(rxEr), .autoneg_speed_strap(autoneg_speed_strap),
    .lineTxValid(lineTxValid), .lineTxDibit(lineTxDibit), .lineCarrier(lineCarrier),
    .lineRxValid(lineRxValid), .lineRxDibit(lineRxDibit), .lineSymErr(lineSymErr),
    .partnerNegotiates(partnerNegotiates), .partnerAbility(partnerAbility),
    .parallelSpeed100(parallelSpeed100), .linkSpeed100(linkSpeed100),
    .linkFullDuplex(linkFullDuplex));
  rmiiph_mac_model u_rmiiph_mac_model (.ref_clk(ref_clk), .rst(rst), .mode50(mode50),
    .refClkOut(refClkOut), .crystal_input(crystal_input), .sendReq(sendReq),
    .idleJunk(1'b1), .pattern(pattern), .nDibits(nDibits), .rep(rep),
    .sendDone(sendDone), .txEn(txEn), .txd(txd));
  // -----------------------------------------------------------------
  // clocks, timeout and transmit capture
  // -----------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;
  // odd start offset keeps the link clock out of phase with ref_clk
  initial #13 forever #40 crystal_input = ~crystal_input;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
    if (lineTxValid === 1'b1) begin
      txCnt++;
      txCap <= {txCap[13:0], lineTxDibit};
    end
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] ad(input logic [5:0] idx);
    return 32'({idx, 2'b00});
  endfunction : ad
  // one single transfer; only the timeout ends a wait for hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
    check({31'h0, hresp}, 32'h0);
  endtask : rdc
  task automatic link(input logic [1:0] e);
    int i;
    for (i = 0; i < 40 && {linkSpeed100, linkFullDuplex} !== e; i++) @(posedge ref_clk);
    check({30'h0, linkSpeed100, linkFullDuplex}, {30'h0, e});
  endtask : link
  // idle junk follows each frame, so a stray strobe shows in the count
  task automatic send(input logic [15:0] p, input logic [3:0] n, input logic [3:0] r);
    int c0;
    int i;
    @(posedge ref_clk);
    c0 = txCnt;
    pattern <= p;
    nDibits <= n;
    rep <= r;
    sendReq <= 1'b1;
    for (i = 0; i < 3000 && sendDone !== 1'b1; i++) @(posedge ref_clk);
    sendReq <= 1'b0;
    repeat (100) @(posedge ref_clk);
    check(32'(txCnt - c0), 32'(n));
    check({16'h0, txCap & ((16'h1 << (2 * n)) - 16'h1)}, {16'h0, p >> (16 - 2 * n)});
  endtask : send
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    int i;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc(ad(IDX_CTRL), {16'h0, CTRL_RST});
    rdc(ad(IDX_ADV), {16'h0, ADV_RST});
    rdc(ad(IDX_MODE), {16'h0, MODE_RST});
    wr(32'h80, 32'hFFFF);
    rdc(32'h80, 32'h0);
    check({31'h0, refClkOutEn}, 32'h1);
    d = 0;
    for (i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      d = d + 32'(refClkOut);
    end
    check(d, 32'(2 * REF_HIGH_CNT));
    link(2'b11);
    send(16'hB4E1, 4'h8, 4'h1);
    lineCarrier <= 1'b1;
    for (i = 0; i < 40 && crsDv !== 1'b1; i++) @(posedge ref_clk);
    check({29'h0, crsDv, rxd}, 32'h4);
    // the MAC rebuilds collision itself; it is idle here, so none may show
    check({30'h0, crsDv, txEn && crsDv}, 32'h2);
    lineRxValid <= 1'b1;
    lineRxDibit <= 2'h2;
    @(posedge ref_clk);
    lineRxValid <= 1'b0;
    for (i = 0; i < 40 && rxd !== 2'h2; i++) @(posedge ref_clk);
    check({29'h0, crsDv, rxd}, 32'h6);
    lineSymErr <= 1'b1;
    @(posedge ref_clk);
    lineSymErr <= 1'b0;
    for (i = 0; i < 40 && rxEr !== 1'b1; i++) @(posedge ref_clk);
    check({30'h0, crsDv, rxEr}, 32'h3);
    lineCarrier <= 1'b0;
    for (i = 0; i < 40 && crsDv !== 1'b0; i++) @(posedge ref_clk);
    check({29'h0, crsDv, rxd}, 32'h0);
    // the MAC gates the error with carrier sense, so none counts now
    check({31'h0, rxEr && crsDv}, 32'h0);
    for (i = 0; i < 6; i++) begin
      partnerAbility <= NEG[i][5:2];
      link(NEG[i][1:0]);
    end
    wr(ad(IDX_ADV), 32'h0061);
    link(2'b01);
    wr(ad(IDX_ADV), {16'h0, ADV_RST});
    partnerNegotiates <= 1'b0;
    link(2'b00);
    parallelSpeed100 <= 1'b1;
    link(2'b10);
    wr(ad(IDX_CTRL), 32'h2100);
    link(2'b11);
    rdc(ad(IDX_CTRL), 32'h2100);
    wr(ad(IDX_CTRL), 32'h0);
    link(2'b00);
    wr(ad(IDX_MODE), 32'h80);
    mode50 <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check({30'h0, refClkOutEn, refClkOut}, 32'h0);
    rdc(ad(IDX_STAT), 32'h08);
    send(16'h9000, 4'h2, 4'(DIBIT_REPEAT_10M));
    autoneg_speed_strap <= 1'b0;
    rst <= 1'b1;
    mode50 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc(ad(IDX_CTRL), 32'h0100);
    rdc(ad(IDX_ADV), 32'h0061);
    rdc(ad(IDX_MODE), {16'h0, MODE_RST});
    link(2'b01);
    end_sim();
  end
endmodule : rmiiph_top_bench
`default_nettype wire
